// ==== design/dmaef_top.sv ====
// DMA event-flag block: status word, write-one clear, channel enables.
// Assumes an APB master on mclk and event pulses from the channel engines on mclk.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "dmaef_regs.svh"
module dmaef_top
	import dmaef_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [`DMAEF_NCH-1:0] transfer_done_event,
	input  wire logic [`DMAEF_NCH-1:0] halfway_event,
	input  wire logic [`DMAEF_NCH-1:0] transfer_fault_event,
	output logic      [`DMAEF_NCH-1:0] channel_enable,
	output logic      [`DMAEF_NCH-1:0] fault_irq
);
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		dmaef_apb_e                ph;
		logic [31:0]               rdata;
		logic                      ready;
		logic                      err;
		logic [`DMAEF_NCH-1:0]     fault_ie;
		logic [`DMAEF_NCH-1:0]     irq;
	} dmaef_top_s;
	dmaef_top_s st, next_st;

	dmaef_word_t             dma_event_status;
	dmaef_word_t             dma_flag_clear;
	logic [`DMAEF_NCH-1:0]   en_now;
	logic                    wr_acc, rd_acc, map_ok;
	logic [`DMAEF_ADDR_W-1:0] addr;

	assign addr   = paddr[`DMAEF_ADDR_W-1:0];
	assign map_ok = (paddr[31:`DMAEF_ADDR_W] == `DMAEF_PAD_RST) &&
		(addr == `DMAEF_ADDR_STATUS || addr == `DMAEF_ADDR_CLEAR ||
		 addr == `DMAEF_ADDR_ENABLE || addr == `DMAEF_ADDR_FLTIE);
	assign wr_acc = psel && penable && pwrite && st.ph == DMAEF_ACCESS && map_ok;
	assign rd_acc = psel && !penable && !pwrite;

	assign dma_flag_clear = (wr_acc && addr == `DMAEF_ADDR_CLEAR) ? pwdata
		: `DMAEF_WORD_RST;

	////////////////////////////////////////////////////////////////////////////
	// channel n at bits 4n..4n+3
	genvar gi;
	generate
		for (gi = 0; gi < `DMAEF_NCH; gi++) begin : g_ch
			dmaef_channel u_ch (
				.mclk      (mclk),
				.nrst      (nrst),
				.done_evt  (transfer_done_event[gi]),
				.half_evt  (halfway_event[gi]),
				.fault_evt (transfer_fault_event[gi]),
				.clr       (dma_flag_clear[`DMAEF_FLAGS_W*gi +: `DMAEF_FLAGS_W]),
				.en_wr     (wr_acc && addr == `DMAEF_ADDR_ENABLE),
				.en_wdata  (pwdata[gi]),
				.flags     (dma_event_status[`DMAEF_FLAGS_W*gi +: `DMAEF_FLAGS_W]),
				.chan_en   (en_now[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st       = st;
		next_st.ready = 1'b0;
		next_st.err   = 1'b0;
		case (st.ph)
			DMAEF_IDLE: begin
				if (psel && !penable) begin
					next_st.ph    = DMAEF_ACCESS;
					next_st.ready = 1'b1;
					next_st.err   = !map_ok;
					next_st.rdata = `DMAEF_WORD_RST;
					if (rd_acc && map_ok) begin
						case (addr)
							`DMAEF_ADDR_STATUS: next_st.rdata = dma_event_status;
							`DMAEF_ADDR_ENABLE: next_st.rdata = {`DMAEF_PAD_RST, en_now};
							`DMAEF_ADDR_FLTIE:  next_st.rdata = {`DMAEF_PAD_RST, st.fault_ie};
							default:            next_st.rdata = `DMAEF_WORD_RST;
						endcase
					end
				end
			end
			DMAEF_ACCESS: begin
				next_st.ph = DMAEF_IDLE;
				if (wr_acc && addr == `DMAEF_ADDR_FLTIE)
					next_st.fault_ie = pwdata[`DMAEF_NCH-1:0];
			end
			default: next_st.ph = DMAEF_IDLE;
		endcase
		next_st.irq = transfer_fault_event & st.fault_ie;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st.ph       <= DMAEF_IDLE;
			st.rdata    <= `DMAEF_WORD_RST;
			st.ready    <= 1'b0;
			st.err      <= 1'b0;
			st.fault_ie <= `DMAEF_BYTE_RST;
			st.irq      <= `DMAEF_BYTE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign prdata         = st.rdata;
	assign pready         = st.ready;
	assign pslverr        = st.err;
	assign channel_enable = en_now;
	assign fault_irq      = st.irq;

	////////////////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	AST_APB_READY: assert property (@(posedge mclk) disable iff (!nrst)
		s_setup |=> pready)
		else $error("pready not raised in access phase");
	AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (!nrst)
		fault_irq != `DMAEF_BYTE_RST |-> $past(st.fault_ie) != `DMAEF_BYTE_RST)
		else $error("fault interrupt raised while disabled");
	AST_RST_ZERO: assert property (@(posedge mclk)
		$rose(nrst) |-> dma_event_status == `DMAEF_WORD_RST)
		else $error("status not zero after reset");
	AST_GCLR: assert property (@(posedge mclk) disable iff (!nrst)
		(dma_flag_clear[0] && transfer_done_event[0] == 1'b0 && halfway_event[0] == 1'b0
		 && transfer_fault_event[0] == 1'b0) |=> dma_event_status[3:0] == `DMAEF_FLAGS_RST)
		else $error("global clear left channel 0 flags set");
	AST_CH7_POS: assert property (@(posedge mclk) disable iff (!nrst)
		transfer_fault_event[7] |=> dma_event_status[31] && dma_event_status[28])
		else $error("channel 7 fault not at bits 31 and 28");
	AST_HALF: assert property (@(posedge mclk) disable iff (!nrst)
		halfway_event[2] |=> dma_event_status[10])
		else $error("channel 2 halfway flag not set");

	////////////////////////////////////////////////////////////////////////////
	// Helpers for the bus-side checks
	logic                    no_evt;
	logic [`DMAEF_NCH-1:0]   irq_due;
	logic [`DMAEF_NCH-1:0]   en_wbyte;
	assign no_evt   = (transfer_done_event | halfway_event | transfer_fault_event)
		== `DMAEF_BYTE_RST;
	assign irq_due  = transfer_fault_event & st.fault_ie;
	assign en_wbyte = pwdata[`DMAEF_NCH-1:0];

	sequence s_wr_status;
		psel && penable && pwrite && pready && map_ok && no_evt
		&& addr == `DMAEF_ADDR_STATUS;
	endsequence
	sequence s_wr_clear;
		psel && penable && pwrite && pready && map_ok && no_evt
		&& addr == `DMAEF_ADDR_CLEAR;
	endsequence
	sequence s_wr_enable;
		psel && penable && pwrite && pready && map_ok && no_evt
		&& addr == `DMAEF_ADDR_ENABLE;
	endsequence
	sequence s_rd_status;
		psel && !penable && !pwrite && map_ok && st.ph == DMAEF_IDLE
		&& addr == `DMAEF_ADDR_STATUS;
	endsequence

	AST_READY_PULSE: assert property (@(posedge mclk) disable iff (!nrst)
		pready |=> !pready)
		else $error("pready held longer than one cycle");

	AST_ERR_WITH_READY: assert property (@(posedge mclk) disable iff (!nrst)
		pslverr |-> pready && prdata == `DMAEF_WORD_RST)
		else $error("pslverr without pready or with nonzero data");

	AST_STATUS_RO: assert property (@(posedge mclk) disable iff (!nrst)
		s_wr_status |=> $stable(dma_event_status))
		else $error("write to status word changed flags");

	AST_CLEAR_ONES: assert property (@(posedge mclk) disable iff (!nrst)
		s_wr_clear |=> (dma_event_status & $past(pwdata)) == `DMAEF_WORD_RST)
		else $error("flag still set after write-one clear");

	AST_EN_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
		s_wr_enable |=> channel_enable == $past(en_wbyte))
		else $error("channel enable does not match written value");

	AST_FAULT_DROPS_EN: assert property (@(posedge mclk) disable iff (!nrst)
		transfer_fault_event != `DMAEF_BYTE_RST
		|=> (channel_enable & $past(transfer_fault_event)) == `DMAEF_BYTE_RST)
		else $error("faulty channel still enabled");

	AST_IRQ_FOLLOW: assert property (@(posedge mclk) disable iff (!nrst)
		irq_due != `DMAEF_BYTE_RST |=> fault_irq == $past(irq_due))
		else $error("fault interrupt does not match enabled faults");

	AST_IRQ_QUIET: assert property (@(posedge mclk) disable iff (!nrst)
		irq_due == `DMAEF_BYTE_RST |=> fault_irq == `DMAEF_BYTE_RST)
		else $error("fault interrupt without enabled fault");

	AST_RD_STATUS: assert property (@(posedge mclk) disable iff (!nrst)
		s_rd_status |=> prdata == $past(dma_event_status))
		else $error("status read data differs from flags");

	AST_ANY_LOW: assert property (@(posedge mclk) disable iff (!nrst)
		(!dma_event_status[`DMAEF_BIT_ANY] && no_evt)
		|=> !dma_event_status[`DMAEF_BIT_ANY])
		else $error("channel 0 global flag set without event");
endmodule // dmaef_top

// ==== design/dmaef_regs.svh ====
// Register map, field layout and reset values of the DMA event-flag block.
// Assumes a 32-bit APB with word-aligned registers.
// Notes on behaviour
// - Any event sets the channel's global flag
// - Transfer done sets done flag, held
// - Halfway point sets halfway flag, held
// - Bus fault sets fault flag, held
// - Flags read-only; write-one clear register only
// - Channel n flags at bits 4n..4n+3
// - All flags reset to zero
// - Fault clears channel enable; gated interrupt
// - Global clear bit clears all four
`ifndef DMAEF_REGS_SVH
`define DMAEF_REGS_SVH
`define DMAEF_ADDR_STATUS   8'h00
`define DMAEF_ADDR_CLEAR    8'h04
`define DMAEF_ADDR_ENABLE   8'h08
`define DMAEF_ADDR_FLTIE    8'h0C
`define DMAEF_ADDR_W        8
`define DMAEF_NCH           8
`define DMAEF_BIT_ANY       0
`define DMAEF_BIT_DONE      1
`define DMAEF_BIT_HALF      2
`define DMAEF_BIT_FAULT     3
`define DMAEF_FLAGS_RST     4'h0
`define DMAEF_WORD_RST      32'h0000_0000
`define DMAEF_BYTE_RST      8'h00
`define DMAEF_FLAGS_W       4
`define DMAEF_PAD_RST       24'h000000
`endif

// ==== design/dmaef_pkg.sv ====
// Types shared by the DMA event-flag block.
// Assumes dmaef_regs.svh is on the include path.
`include "dmaef_regs.svh"
package dmaef_pkg;
	typedef logic [3:0]  dmaef_flags_t;
	typedef logic [31:0] dmaef_word_t;
	typedef enum logic {DMAEF_IDLE, DMAEF_ACCESS} dmaef_apb_e;
endpackage

// ==== design/dmaef_channel.sv ====
// Four event flags of one channel plus its enable bit.
// Assumes set pulses and clear strobes are on mclk.
`timescale 1ns/100ps
module dmaef_channel
	import dmaef_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic         done_evt,
	input  wire logic         half_evt,
	input  wire logic         fault_evt,
	input  wire dmaef_flags_t clr,
	input  wire logic         en_wr,
	input  wire logic         en_wdata,
	output dmaef_flags_t      flags,
	output logic              chan_en
);
	typedef struct packed {
		dmaef_flags_t f;
		logic         en;
	} dmaef_ch_s;
	dmaef_ch_s st, next_st;
	logic any_evt, clr_all;

	always_comb begin
		next_st = st;
		any_evt = done_evt | half_evt | fault_evt;
		clr_all = clr[`DMAEF_BIT_ANY];
		if (clr_all)
			next_st.f = `DMAEF_FLAGS_RST;
		else
			next_st.f = st.f & ~clr;
		if (any_evt)
			next_st.f[`DMAEF_BIT_ANY] = 1'b1;
		if (done_evt)
			next_st.f[`DMAEF_BIT_DONE] = 1'b1;
		if (half_evt)
			next_st.f[`DMAEF_BIT_HALF] = 1'b1;
		if (fault_evt)
			next_st.f[`DMAEF_BIT_FAULT] = 1'b1;
		if (en_wr)
			next_st.en = en_wdata;
		if (fault_evt)
			next_st.en = 1'b0;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st.f  <= `DMAEF_FLAGS_RST;
			st.en <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign flags   = st.f;
	assign chan_en = st.en;

	AST_FAULT_SETS: assert property (@(posedge mclk) disable iff (!nrst)
		fault_evt |=> flags[`DMAEF_BIT_FAULT] && flags[`DMAEF_BIT_ANY] && !chan_en)
		else $error("fault event did not set flag or drop enable");
	AST_SET_WINS: assert property (@(posedge mclk) disable iff (!nrst)
		(done_evt && clr_all) |=> flags[`DMAEF_BIT_DONE])
		else $error("done flag lost to simultaneous clear");
	AST_DONE_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
		(flags[`DMAEF_BIT_DONE] && !clr[`DMAEF_BIT_DONE] && !clr_all)
		|=> flags[`DMAEF_BIT_DONE])
		else $error("done flag dropped without clear");
	AST_ANY_COVERS: assert property (@(posedge mclk) disable iff (!nrst)
		(flags[3:1] != 3'b000) |-> flags[`DMAEF_BIT_ANY])
		else $error("global flag low while an event flag is set");
endmodule // dmaef_channel

// ==== tb/tb_dma_channel_event_flags.sv ====
// Self-checking bench for the DMA event-flag block.
// Assumes one-cycle APB answers and one-cycle event pulses.
`timescale 1ns/100ps
`include "dmaef_regs.svh"
module tb_dma_channel_event_flags
	import dmaef_pkg::*;
;
localparam logic [31:0] A_ST = 32'h0, A_CL = 32'h4, A_EN = 32'h8, A_IE = 32'hC, A_BAD = 32'h10;
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, a); end end
logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
logic [31:0] paddr, pwdata, prdata, rd, r;
logic [7:0]  ev_d, ev_h, ev_f, pd, ph, pf, chen, irq, exp_en, exp_ie;
dmaef_word_t exp_s;
int          seed = 67676;
int          fail_count, total_checks, cyc;
////////////////////////////////////////////////////////////////////////
dmaef_top u_dmaef_top (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .transfer_done_event(ev_d), .halfway_event(ev_h),
	.transfer_fault_event(ev_f), .channel_enable(chen), .fault_irq(irq));
initial begin
	mclk = 0;
	forever #2 mclk = ~mclk;
end
////////////////////////////////////////////////////////////////////////
// Next status: clears, then sets win
function automatic dmaef_word_t nxt(dmaef_word_t s, logic [31:0] c, logic [7:0] d, h, f);
	logic [3:0] m;
	for (int n = 0; n < 8; n++) begin
		m = c[4*n+:4];
		if (m[0]) m = 4'hF;
		s[4*n+:4] = (s[4*n+:4] & ~m) | {f[n], h[n], d[n], d[n] | h[n] | f[n]};
	end
	return s;
endfunction
task automatic apb(input logic w, input logic [31:0] a, d);
	@(posedge mclk);
	psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
	@(posedge mclk);
	penable <= 1; ev_d <= pd; ev_h <= ph; ev_f <= pf;
	@(posedge mclk);
	while (pready !== 1'b1) @(posedge mclk);
	rd = prdata;
	err = pslverr;
	psel <= 0; penable <= 0; ev_d <= 0; ev_h <= 0; ev_f <= 0;
	exp_s = nxt(exp_s, (w && a == A_CL) ? d : 32'h0, pd, ph, pf);
	if (w && a == A_EN) exp_en = d[7:0];
	if (w && a == A_IE) exp_ie = d[7:0];
	exp_en &= ~pf;
endtask
task automatic rdchk(input logic [31:0] a, e, input string nm);
	apb(0, a, 32'h0);
	`CHK(nm, e, rd)
	`CHK("slverr", 1'b0, err)
endtask
task automatic pulse(input logic [7:0] d, h, f);
	@(posedge mclk);
	ev_d <= d; ev_h <= h; ev_f <= f;
	@(posedge mclk);
	ev_d <= 0; ev_h <= 0; ev_f <= 0;
	@(negedge mclk);
	`CHK("irq", f & exp_ie, irq)
	exp_s = nxt(exp_s, 32'h0, d, h, f);
	exp_en &= ~f;
	`CHK("enable", exp_en, chen)
endtask
task automatic final_report();
	$display("checks %0d mismatches %0d", total_checks, fail_count);
	if (fail_count == 0 && total_checks > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
always @(posedge mclk) begin
	cyc++;
	if (cyc == 20000) begin
		fail_count++;
		final_report();
	end
end
////////////////////////////////////////////////////////////////////////
initial begin
	nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
	ev_d = 0; ev_h = 0; ev_f = 0; pd = 0; ph = 0; pf = 0;
	exp_s = 0; exp_en = 0; exp_ie = 0;
	repeat (16) @(posedge mclk);
	nrst <= 1;
	rdchk(A_ST, 32'h0, "status");
	rdchk(A_EN, 32'h0, "enable");
	rdchk(A_IE, 32'h0, "fltie");
	rdchk(A_CL, 32'h0, "clear_rd");
	$display("test reset done");
	for (int n = 0; n < 8; n++) begin
		for (int k = 1; k < 4; k++) begin
			pulse(8'(k == 1) << n, 8'(k == 2) << n, 8'(k == 3) << n);
			rdchk(A_ST, exp_s, "status");
			`CHK("layout", (32'h1 | (32'h1 << k)) << (4 * n), rd)
			apb(1, A_CL, 32'h1 << (4 * n));
			rdchk(A_ST, 32'h0, "gclear");
		end
	end
	$display("test walk done");
	for (int i = 0; i < 40; i++) begin
		apb(1, A_EN, $random(seed));
		apb(1, A_IE, $random(seed));
		r = $random(seed);
		pulse(r[7:0], r[15:8], r[23:16]);
		rdchk(A_ST, exp_s, "status");
		apb(1, A_ST, r);
		rdchk(A_ST, exp_s, "ro_status");
		r = $random(seed);
		pd = r[7:0]; ph = r[15:8]; pf = r[23:16];
		apb(1, A_CL, (i % 4 == 0) ? 32'hFFFFFFFF : $random(seed));
		pd = 0; ph = 0; pf = 0;
		rdchk(A_ST, exp_s, "set_wins");
		rdchk(A_EN, {24'h0, exp_en}, "enable");
	end
	$display("test random done");
	apb(1, A_BAD, 32'hFFFFFFFF);
	`CHK("bad_wr_err", 1'b1, err)
	apb(0, A_BAD, 32'h0);
	`CHK("bad_rd_err", 1'b1, err)
	`CHK("bad_rd_data", 32'h0, rd)
	rdchk(A_ST, exp_s, "status");
	$display("test unmapped done");
	final_report();
end
endmodule // tb_dma_channel_event_flags
